// [common/pmcc_consts.svh]
// Constants of the power-mode clock controller: register offsets,
// field positions, reset values and bus response codes.
// Assumes inclusion by bare name from any file that needs them.
`ifndef PMCC_CONSTS_SVH
`define PMCC_CONSTS_SVH
`define PMCC_ADDR_W 8
`define PMCC_OFF_PLLCTL 8'h00
`define PMCC_OFF_MODEREQ 8'h04
`define PMCC_OFF_STATUS 8'h08
`define PMCC_OFF_PCLKEN 8'h0c
`define PMCC_OFF_VLEVEL 8'h10
`define PMCC_OFF_WAKEEN 8'h14
`define PMCC_BIT_PLLOFF 0
`define PMCC_BIT_BYPASS 1
`define PMCC_MODE_W 3
`define PMCC_MODE_COUNT 3'h5
`define PMCC_VLEVEL_W 4
`define PMCC_VLEVEL_RST 4'h8
`define PMCC_RESP_OKAY 2'h0
`define PMCC_RESP_SLVERR 2'h2
`endif

// [common/pmcc_pkg.sv]
// Types shared by the power-mode clock controller files.
// Assumes pmcc_consts.svh is on the include path.
`include "pmcc_consts.svh"
package pmcc_pkg;
   // Operating modes, in order of falling power
   typedef enum logic [`PMCC_MODE_W-1:0] {
      pmcc_full_on,
      pmcc_active,
      pmcc_sleep,
      pmcc_deep_sleep,
      pmcc_hibernate
   } pmcc_mode_t;

   // One register write, as handed from the bus slave
   typedef struct packed {
      logic [`PMCC_ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } pmcc_wr_t;

   // Clocking and power outputs of one mode
   typedef struct packed {
      logic pll_en;
      logic pll_bypass;
      logic core_clk_en;
      logic sys_clk_en;
      logic core_power_on;
   } pmcc_pwr_t;

   // Merge write data into an old word under byte strobes
   function automatic logic [31:0] pmcc_merge(input logic [31:0] old,
         input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction
endpackage

// [core/pmcc_gate.sv]
// Bank of registered gate enables for clock and power controls.
// Assumes the clock gate cells downstream latch the enable on the low
// phase, so an enable that changes only at a rising edge cannot glitch.
`timescale 1ns/10ps
`default_nettype none
module pmcc_gate #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Wanted and applied enables
   input wire logic [W-1:0] en_d,
   output var logic [W-1:0] en_q
);
   // Each enable moves only on a clock edge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         en_q <= RST_VAL;
      end else begin
         en_q <= en_d;
      end
   end
endmodule // pmcc_gate
`default_nettype wire

// [core/pmcc_axil.sv]
// AXI4-Lite slave front end for the power-mode clock controller.
// Assumes the register file answers a read address combinationally.
`timescale 1ns/10ps
`default_nettype none
`include "pmcc_consts.svh"
module pmcc_axil
   import pmcc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [`PMCC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // Write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // Read address and data
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [`PMCC_ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Register file side
   output logic wr_en,
   output pmcc_wr_t wr,
   input wire logic wr_ok,
   output logic [`PMCC_ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_have_q, w_have_q, ar_have_q, bvalid_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;

   // One write at a time: channels close while a response is pending
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign s_axi_arready = !ar_have_q && !rvalid_q;
   assign wr_en = aw_have_q && w_have_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Write side: address and data may arrive in either order
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `PMCC_RESP_OKAY;
         wr <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            wr.addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wr.data <= s_axi_wdata;
            wr.strb <= s_axi_wstrb;
         end
         if (wr_en) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? `PMCC_RESP_OKAY : `PMCC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read side: address held one cycle, data registered the next
   logic [`PMCC_ADDR_W-1:0] ar_addr_q;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ar_have_q <= 1'b0;
         ar_addr_q <= '0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `PMCC_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            ar_have_q <= 1'b1;
            ar_addr_q <= s_axi_araddr;
         end
         if (ar_have_q) begin
            ar_have_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_ok ? rd_data : 32'h0000_0000;
            rresp_q <= rd_ok ? `PMCC_RESP_OKAY : `PMCC_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end
   assign rd_addr = ar_addr_q;
endmodule // pmcc_axil
`default_nettype wire

// [core/pmcc_top.sv]
// Power-mode clock controller: mode state machine, register file,
// clock gate and power enables for the core and system domains.
// Assumes a free-running input clock; gate cells and the PLL mux are
// outside, steered by the registered enables this block drives.
`timescale 1ns/10ps
`default_nettype none
`include "pmcc_consts.svh"

// What this block does
// RULE_01 - Five modes exist, each with its own PLL, clock and power mix.
// RULE_02 - Full-on keeps the PLL on and unbypassed, clocks at full rate.
// RULE_03 - Leaving reset the block sits in full-on with no software help.
// RULE_04 - Active bypasses the PLL and keeps core and system clocks on.
// RULE_05 - With the PLL bypassed both clocks come from the input clock.
// RULE_06 - Active mode still lets DMA reach first-level memory.
// RULE_07 - In active mode the PLL off bit removes the PLL control input.
// RULE_08 - Software clears PLL off before asking active for full-on/sleep.
// RULE_09 - Every peripheral has its own software clock gate.
// RULE_10 - Software sets the core voltage level at any time in any mode.
// RULE_11 - Sleep stops core clock only; wake goes full-on or active.
// RULE_12 - Deep sleep stops both clocks; the RTC interrupt leads to active.
// RULE_13 - Hibernate drops power; any enabled wake starts a full reset.
// RULE_14 - Sleep blocks system DMA into first-level memory.
// RULE_15 - Mode shows in status, and enables move only on clock edges.
module pmcc_top
   import pmcc_pkg::*;
#(
   parameter int NPERIPH = 32,
   parameter int NWAKE = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // AXI4-Lite write channels
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [`PMCC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read channels
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [`PMCC_ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Wake sources
   input wire logic [NWAKE-1:0] wake_events,
   input wire logic rtc_irq,
   // Clock, power and DMA controls
   output pmcc_pwr_t pwr,
   output logic [NPERIPH-1:0] periph_clk_en,
   output logic [`PMCC_VLEVEL_W-1:0] vlevel,
   output logic l1_dma_allow,
   output logic reset_seq_req,
   output pmcc_mode_t mode
);
   //--------------------------------------------------------------------
   // Bus front end
   //--------------------------------------------------------------------
   logic wr_en, wr_ok, rd_ok;
   pmcc_wr_t wr;
   logic [`PMCC_ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;

   pmcc_axil u_axil (
      .sys_clk(sys_clk),
      .rst(rst),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .wr_en(wr_en),
      .wr(wr),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   //--------------------------------------------------------------------
   // Address decode
   //--------------------------------------------------------------------
   // Only whole-word offsets in the map are answered with OKAY
   function automatic logic pmcc_mapped(input logic [`PMCC_ADDR_W-1:0] a);
      return (a == `PMCC_OFF_PLLCTL) || (a == `PMCC_OFF_MODEREQ) ||
             (a == `PMCC_OFF_STATUS) || (a == `PMCC_OFF_PCLKEN) ||
             (a == `PMCC_OFF_VLEVEL) || (a == `PMCC_OFF_WAKEEN);
   endfunction

   assign wr_ok = pmcc_mapped(wr.addr);
   assign rd_ok = pmcc_mapped(rd_addr);

   logic wr_pllctl, wr_modereq, wr_pclken, wr_vlevel, wr_wakeen;
   assign wr_pllctl = wr_en && (wr.addr == `PMCC_OFF_PLLCTL);
   assign wr_modereq = wr_en && (wr.addr == `PMCC_OFF_MODEREQ) &&
                       wr.strb[0];
   assign wr_pclken = wr_en && (wr.addr == `PMCC_OFF_PCLKEN);
   assign wr_vlevel = wr_en && (wr.addr == `PMCC_OFF_VLEVEL);
   assign wr_wakeen = wr_en && (wr.addr == `PMCC_OFF_WAKEEN);

   //--------------------------------------------------------------------
   // Software-owned registers
   //--------------------------------------------------------------------
   logic pll_off_q, bypass_q;
   logic [NPERIPH-1:0] pclken_q;
   logic [`PMCC_VLEVEL_W-1:0] vlevel_q;
   logic [NWAKE-1:0] wakeen_q;
   logic [31:0] pllctl_word, pclken_word, wake_word, vlevel_word;
   logic [31:0] pllctl_new, pclken_new, wake_new, vlevel_new;

   // Zero-extended views so the strobe merge works on whole words
   assign pllctl_word = {30'h0, bypass_q, pll_off_q};
   assign pclken_word = 32'(pclken_q);
   assign wake_word = 32'(wakeen_q);
   assign vlevel_word = 32'(vlevel_q);
   assign pllctl_new = pmcc_merge(pllctl_word, wr.data, wr.strb);
   assign pclken_new = pmcc_merge(pclken_word, wr.data, wr.strb);
   assign wake_new = pmcc_merge(wake_word, wr.data, wr.strb);
   assign vlevel_new = pmcc_merge(vlevel_word, wr.data, wr.strb);

   // Per-peripheral clock gates, all running after reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pclken_q <= '1;
      end else if (wr_pclken) begin
         pclken_q <= pclken_new[NPERIPH-1:0]; // [RULE_09]
      end
   end

   // Core voltage request is free of the mode machine
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         vlevel_q <= `PMCC_VLEVEL_RST;
      end else if (wr_vlevel) begin
         vlevel_q <= vlevel_new[`PMCC_VLEVEL_W-1:0]; // [RULE_10]
      end
   end

   // Wake enable mask for sleep and hibernate exits
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wakeen_q <= '0;
      end else if (wr_wakeen) begin
         wakeen_q <= wake_new[NWAKE-1:0];
      end
   end

   //--------------------------------------------------------------------
   // Mode state machine
   //--------------------------------------------------------------------
   pmcc_mode_t mode_q, mode_d, req_mode;
   logic req_legal, req_refused_q, wake_hit, reset_req_q;

   assign req_mode = pmcc_mode_t'(wr.data[`PMCC_MODE_W-1:0]);
   assign wake_hit = |(wake_events & wakeen_q);

   // Legal software requests; only a running core can issue them.
   // A PLL left off blocks the way back to full-on or sleep.
   always_comb begin
      req_legal = 1'b0;
      if (wr.data[`PMCC_MODE_W-1:0] < `PMCC_MODE_COUNT) begin
         case (mode_q)
            pmcc_full_on: req_legal = 1'b1;
            pmcc_active: begin
               req_legal = !(pll_off_q && ((req_mode == pmcc_full_on) ||
                           (req_mode == pmcc_sleep))); // [RULE_08]
            end
            default: req_legal = 1'b0;
         endcase
      end
   end

   // Next mode from requests and wake events
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         pmcc_full_on, pmcc_active: begin
            if (wr_modereq && req_legal) begin
               mode_d = req_mode; // [RULE_01]
            end
         end
         pmcc_sleep: begin
            if (wake_hit) begin
               mode_d = bypass_q ? pmcc_active : pmcc_full_on; // [RULE_11]
            end
         end
         pmcc_deep_sleep: begin
            if (rtc_irq) begin
               mode_d = pmcc_active; // [RULE_12]
            end
         end
         pmcc_hibernate: mode_d = pmcc_hibernate;
         default: mode_d = pmcc_full_on;
      endcase
   end

   // Mode register; reset lands in full-on
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_q <= pmcc_full_on; // [RULE_03] [RULE_13]
      end else begin
         mode_q <= mode_d; // [RULE_15]
      end
   end

   // Hibernate never resumes: a wake asks for the full reset sequence,
   // held until the chip reset comes back round to clear it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reset_req_q <= 1'b0;
      end else if ((mode_q == pmcc_hibernate) && (wake_hit || rtc_irq)) begin
         reset_req_q <= 1'b1; // [RULE_13]
      end
   end

   // Refusal flag; each mode request sets it if refused and clears it if legal
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         req_refused_q <= 1'b0;
      end else if (wr_modereq) begin
         req_refused_q <= !req_legal;
      end
   end

   // PLL control bits. Entering active forces bypass on and full-on
   // forces it off, so the bit always tells sleep where to return.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pll_off_q <= 1'b0;
         bypass_q <= 1'b0;
      end else begin
         if (wr_pllctl) begin
            pll_off_q <= pllctl_new[`PMCC_BIT_PLLOFF];
            bypass_q <= pllctl_new[`PMCC_BIT_BYPASS];
         end
         if ((mode_d == pmcc_active) && (mode_q != pmcc_active)) begin
            bypass_q <= 1'b1;
         end else if ((mode_d == pmcc_full_on) &&
                      (mode_q != pmcc_full_on)) begin
            bypass_q <= 1'b0;
         end
      end
   end

   //--------------------------------------------------------------------
   // Per-mode clock and power settings
   //--------------------------------------------------------------------
   pmcc_pwr_t pwr_d;
   logic dma_d;

   // Settings follow the next mode so they change with the mode register
   always_comb begin
      pwr_d = '0;
      dma_d = 1'b0;
      case (mode_d)
         pmcc_full_on: begin
            pwr_d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1}; // [RULE_02]
            dma_d = 1'b1;
         end
         pmcc_active: begin
            // Bypass puts both clocks on the input clock
            pwr_d = '{!pll_off_q, 1'b1, 1'b1, 1'b1, 1'b1}; // [RULE_04]
            pwr_d.pll_en = !pll_off_q; // [RULE_07] [RULE_05]
            dma_d = 1'b1; // [RULE_06]
         end
         pmcc_sleep: begin
            pwr_d = '{1'b1, bypass_q, 1'b0, 1'b1, 1'b1}; // [RULE_11]
            dma_d = 1'b0; // [RULE_14]
         end
         pmcc_deep_sleep: begin
            pwr_d = '{1'b0, bypass_q, 1'b0, 1'b0, 1'b1}; // [RULE_12]
         end
         pmcc_hibernate: begin
            pwr_d = '{1'b0, bypass_q, 1'b0, 1'b0, 1'b0}; // [RULE_13]
         end
         default: begin
            pwr_d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
            dma_d = 1'b1;
         end
      endcase
   end

   //--------------------------------------------------------------------
   // Registered enables
   //--------------------------------------------------------------------
   // Flop stages keep every gate and select free of decode glitches
   logic [5:0] ctl_q;
   pmcc_gate #(.W(6), .RST_VAL(6'h2f)) u_ctl_gate (
      .sys_clk(sys_clk),
      .rst(rst),
      .en_d({pwr_d, dma_d}),
      .en_q(ctl_q)
   ); // [RULE_15]

   pmcc_gate #(.W(NPERIPH), .RST_VAL('1)) u_pclk_gate (
      .sys_clk(sys_clk),
      .rst(rst),
      .en_d(pclken_q & {NPERIPH{pwr_d.sys_clk_en}}),
      .en_q(periph_clk_en)
   ); // [RULE_09]

   assign pwr = ctl_q[5:1];
   assign l1_dma_allow = ctl_q[0];
   assign vlevel = vlevel_q;
   assign reset_seq_req = reset_req_q;
   assign mode = mode_q;

   //--------------------------------------------------------------------
   // Read mux
   //--------------------------------------------------------------------
   // Status shows the live mode and applied enables
   always_comb begin
      rd_data = 32'h0000_0000;
      case (rd_addr)
         `PMCC_OFF_PLLCTL: rd_data = pllctl_word;
         `PMCC_OFF_STATUS: begin
            rd_data = {21'h0, reset_req_q, req_refused_q, ctl_q,
                       mode_q}; // [RULE_15]
         end
         `PMCC_OFF_PCLKEN: rd_data = pclken_word;
         `PMCC_OFF_VLEVEL: rd_data = vlevel_word;
         `PMCC_OFF_WAKEEN: rd_data = wake_word;
         default: rd_data = 32'h0000_0000;
      endcase
   end
endmodule // pmcc_top
`default_nettype wire

// [dv/pmcc_chk.sv]
// Checker for the power-mode clock controller, bound to pmcc_top.
// Assumes it sees only the top ports, all on sys_clk with sync rst.
`timescale 1ns/10ps
`default_nettype none
module pmcc_chk
   import pmcc_pkg::*;
#(
   parameter int NPERIPH = 32,
   parameter int NWAKE = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Wake sources
   input wire logic [NWAKE-1:0] wake_events,
   input wire logic rtc_irq,
   // Controls watched
   input wire pmcc_pwr_t pwr,
   input wire logic [NPERIPH-1:0] periph_clk_en,
   input wire logic l1_dma_allow,
   input wire logic reset_seq_req,
   input wire pmcc_mode_t mode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   //--------------------------------------------------------------
   // Settings of each mode
   //--------------------------------------------------------------
   a_full_on_pwr: assert property (
      mode == pmcc_full_on |-> pwr == 5'b10111) else $error("full-on bad");
   a_active_clks: assert property (
      mode == pmcc_active |-> pwr[3:0] == 4'hf && l1_dma_allow)
      else $error("active controls bad");
   a_sleep_clks: assert property (
      mode == pmcc_sleep |-> pwr.pll_en && pwr[2:0] == 3'b011
      && !l1_dma_allow) else $error("sleep controls bad");
   a_deep_clks: assert property (
      mode == pmcc_deep_sleep |-> !pwr.pll_en && pwr[2:0] == 3'b001)
      else $error("deep sleep controls bad");
   a_hib_power: assert property (
      mode == pmcc_hibernate |-> !pwr.pll_en && pwr[2:0] == 3'b000)
      else $error("hibernate controls bad");
   a_mode_legal: assert property (
      mode <= pmcc_hibernate) else $error("mode code out of range");
   // Transitions; a stopped system clock must also stop peripherals
   a_reset_full: assert property (
      $fell(rst) |-> mode == pmcc_full_on && !reset_seq_req)
      else $error("reset did not give full-on");
   a_deep_exit: assert property (
      mode == pmcc_deep_sleep && rtc_irq |=> mode == pmcc_active)
      else $error("rtc did not leave deep sleep");
   a_deep_stay: assert property (
      mode == pmcc_deep_sleep && !rtc_irq |=> mode == pmcc_deep_sleep)
      else $error("deep sleep left without rtc");
   a_hib_wake: assert property (
      mode == pmcc_hibernate && rtc_irq |=> reset_seq_req [*2])
      else $error("hibernate wake gave no reset request");
   a_hib_stays: assert property (
      reset_seq_req |=> mode == pmcc_hibernate) else $error("hib left");
   a_periph_off: assert property (
      !pwr.sys_clk_en |-> periph_clk_en == '0) else $error("periph on");
   c_sleep: cover property (mode == pmcc_sleep);
   c_deep_exit: cover property (mode == pmcc_deep_sleep && rtc_irq);
   c_hib_wake: cover property (reset_seq_req && mode == pmcc_hibernate);
endmodule // pmcc_chk
bind pmcc_top pmcc_chk #(.NPERIPH(NPERIPH), .NWAKE(NWAKE)) pmcc_chk_inst (.*);
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for pmcc_top over its AXI4-Lite port.
// Assumes the package and constants header compile first.
`timescale 1ns/10ps
`default_nettype none
`include "pmcc_consts.svh"
module testbench;
   import pmcc_pkg::*;
   logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, rtc_irq;
   logic l1_dma_allow, reset_seq_req;
   logic [7:0] s_axi_awaddr, s_axi_araddr, wake_events;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_q, periph_clk_en;
   logic [3:0] s_axi_wstrb, vlevel;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
   pmcc_pwr_t pwr;
   pmcc_mode_t mode;
   int n_errors, check_count, cycles;
   pmcc_top #(.NPERIPH(32), .NWAKE(8)) pmcc_top_inst (.*);
   //--------------------------------------------------------------
   // Clock, watchdog and report
   //--------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // A hung handshake would otherwise stall the run for ever
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   //--------------------------------------------------------------
   // Bus master tasks; each waits for the slave's answer
   //--------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge sys_clk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      resp_q = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Request a mode, then look once the outputs have settled
   task automatic go(input logic [31:0] m);
      wr(`PMCC_OFF_MODEREQ, m);
      @(negedge sys_clk);
   endtask
   //--------------------------------------------------------------
   // Scenarios
   //--------------------------------------------------------------
   task automatic t_regs();
      @(negedge sys_clk);
      check("mode", 32'(mode), 32'h0);
      check("pwr", 32'(pwr), 32'h17);
      check("vlevel", 32'(vlevel), 32'h8);
      wr(`PMCC_OFF_PCLKEN, 32'h0000_00a5);
      wr(`PMCC_OFF_VLEVEL, 32'h3);
      @(negedge sys_clk);
      check("periph", periph_clk_en, 32'ha5);
      check("vlevel", 32'(vlevel), 32'h3);
      rd(8'h20);
      check("rresp", 32'(resp_q), 32'h2);
      check("rdata", rd_q, 32'h0);
      wr(8'h20, 32'h1);
      check("bresp", 32'(resp_q), 32'h2);
      go(32'h7);
      rd(`PMCC_OFF_STATUS);
      check("status", rd_q, 32'h378);
      wr(`PMCC_OFF_WAKEEN, 32'h1);
   endtask
   // Sleep, ignore a masked wake, then leave on an enabled one
   task automatic t_sleep(input logic [31:0] back);
      go(32'h2);
      check("sleep pwr", 32'(pwr[2:0]), 32'h3);
      check("dma", 32'(l1_dma_allow), 32'h0);
      @(posedge sys_clk);
      wake_events <= 8'h02;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      check("masked wake", 32'(mode), 32'h2);
      @(posedge sys_clk);
      wake_events <= 8'h01;
      repeat (2) @(posedge sys_clk);
      wake_events <= 8'h00;
      @(negedge sys_clk);
      check("wake mode", 32'(mode), back);
   endtask
   task automatic t_active();
      go(32'h1);
      check("act pwr", 32'(pwr), 32'h1f);
      check("dma", 32'(l1_dma_allow), 32'h1);
      rd(`PMCC_OFF_STATUS);
      check("status", rd_q, 32'h1f9);
      wr(`PMCC_OFF_PLLCTL, 32'h3);
      @(negedge sys_clk);
      check("pll_en", 32'(pwr.pll_en), 32'h0);
      go(32'h0);
      rd(`PMCC_OFF_STATUS);
      check("status", rd_q, 32'h2f9);
      wr(`PMCC_OFF_PLLCTL, 32'h2);
   endtask
   task automatic t_deep();
      go(32'h3);
      check("deep pwr", 32'({pwr.pll_en, pwr[2:0]}), 32'h1);
      check("periph", periph_clk_en, 32'h0);
      @(posedge sys_clk);
      rtc_irq <= 1'b1;
      @(posedge sys_clk);
      rtc_irq <= 1'b0;
      @(negedge sys_clk);
      check("deep exit", 32'(mode), 32'h1);
      check("periph", periph_clk_en, 32'ha5);
   endtask
   task automatic t_hib();
      go(32'h4);
      check("hib pwr", 32'({pwr.pll_en, pwr[2:0]}), 32'h0);
      @(posedge sys_clk);
      wake_events <= 8'h01;
      @(posedge sys_clk);
      wake_events <= 8'h00;
      repeat (2) @(negedge sys_clk);
      check("reset_seq", 32'(reset_seq_req), 32'h1);
      check("hib mode", 32'(mode), 32'h4);
      // The RTC is a hibernate wake source of its own
      @(posedge sys_clk);
      rtc_irq <= 1'b1;
      @(posedge sys_clk);
      rtc_irq <= 1'b0;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      check("mode", 32'(mode), 32'h0);
   endtask
   // Main sequence: idle inputs, 3-cycle reset, then the scenarios
   initial begin
      {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, rtc_irq} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, wake_events} = '0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_sleep(32'h0);
      t_active();
      t_sleep(32'h1);
      t_deep();
      t_hib();
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
